//--- shared/sacc_pkg.sv
/*
  Constants, register map and carrier types for the SAR converter control block.
  Assumes a 100 MHz bus clock; all other files import this package.
*/
package sacc_pkg;

  // ==========================================================
  // Register map (byte addresses, one aligned word each)
  localparam logic [3:0] SACC_ADDR_SC = 4'h0;
  localparam logic [3:0] SACC_ADDR_CLK = 4'h4;
  localparam logic [3:0] SACC_ADDR_RH = 4'h8;
  localparam logic [3:0] SACC_ADDR_RL = 4'hC;

  // ==========================================================
  // Field positions
  localparam int SACC_SC_FLAG_BIT = 7;
  localparam logic [4:0] SACC_CHAN_OFF = 5'h1F;
  localparam logic [4:0] SACC_SC_RST_CHAN = 5'h1F;

  // ==========================================================
  // Timing
  localparam int SACC_BUS_MHZ = 100;
  localparam int SACC_STARTUP_NS = 5000;
  localparam logic [9:0] SACC_STARTUP_CYC = 10'((SACC_STARTUP_NS * SACC_BUS_MHZ + 999) / 1000);
  localparam logic [9:0] SACC_SYNC_CYC = 10'h003;
  localparam logic [9:0] SACC_FIRST_EXTRA_CONVERTER_CLOCK = 10'h002;
  localparam logic [3:0] SACC_SAR_MSB = 4'hA;
  localparam int SACC_SAR_STEPS = 11;
  localparam int SACC_SUB_8S = 16;
  localparam int SACC_SUB_8L = 36;
  localparam int SACC_SUB_10S = 19;
  localparam int SACC_SUB_10L = 39;
  localparam logic [9:0] SACC_SMP_8S = 10'(SACC_SUB_8S - SACC_SAR_STEPS);
  localparam logic [9:0] SACC_SMP_8L = 10'(SACC_SUB_8L - SACC_SAR_STEPS);
  localparam logic [9:0] SACC_SMP_10S = 10'(SACC_SUB_10S - SACC_SAR_STEPS);
  localparam logic [9:0] SACC_SMP_10L = 10'(SACC_SUB_10L - SACC_SAR_STEPS);

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SACC_IDLE = 3'h0,
    SACC_SYNC = 3'h1,
    SACC_STARTUP = 3'h3,
    SACC_SETTLE = 3'h2,
    SACC_SAMPLE = 3'h6,
    SACC_CONVERT = 3'h7,
    SACC_TRANSFER = 3'h5
  } sacc_state_t;

  typedef struct packed {
    logic complete_irq_enable;
    logic continuous_select;
    logic [4:0] channel_select;
  } sacc_sc_t;

  typedef struct packed {
    logic resolution_10;
    logic low_power_config;
    logic long_sample_select;
    logic [1:0] clock_divide;
    logic async_clock_enable;
    logic input_clock_select;
  } sacc_clk_t;

  localparam sacc_sc_t SACC_SC_RST = '{1'b0, 1'b0, SACC_SC_RST_CHAN};
  localparam sacc_clk_t SACC_CLK_RST = '{1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b0};

endpackage

//--- verilog/sacc_top.sv
/*
  SAR converter control: clock select and divide, channel mux control, SAR sequencing,
  result formatting, completion flag, interrupt and read blocking, Avalon-MM slave.
  Assumes an analog comparator outside whose output arrives asynchronously on a pin,
  and oscillator/asynchronous clocks arriving as pins sampled on sys_clk.
*/
// The Avalon-MM register port and the address map were decided locally.
// What this block does
// - Eleven-bit SAR; 8-bit rounds into low result
// - Saturate to all ones at full scale
// - Pick async, alternate or bus source clock
// - Async clock runs only converting; range bit
// - Async clock keeps running in stop mode
// - Divide source by 1, 2, 4, 8
// - Route exactly one selected input channel
// - Resolution field selects 10 or 8 bits
// - No hardware trigger; software or continuous only
// - Control write starts conversion unless channel ones
// - Continuous mode restarts after every transfer
// - Transfer result, set flag, interrupt if enabled
// - High read pending blocks transfer, discards result
// - Blocked transfer always starts another conversion
// - Abort on control writes, reset, stop
// - Abort keeps last result; reset clears it
// - Abort drops clocks and references immediately
// - 8-bit short: 18 plus 3, then 16
// - 8-bit long: 38 plus 3, then 36
// - 10-bit short: 21 plus 3, then 19
// - 10-bit long: 41 plus 3, then 39
// - Single conversion ends in low-power idle
`timescale 1ns/10ps
module sacc_top
  import sacc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // System
  input wire logic stop_mode,
  output logic irq,
  // Clock pins
  input wire logic oscillator_clock,
  input wire logic async_clock_pin,
  output logic async_osc_enable,
  output logic async_osc_low_power,
  // Analog front end
  input wire logic comparator_in,
  output logic [4:0] converter_input,
  output logic mux_enable,
  output logic sample_enable,
  output logic ref_enable,
  output logic [10:0] sar_code
);
  import sacc_pkg::*;

  // ==========================================================
  // Registers
  sacc_state_t state_ff, nxt_state;
  sacc_sc_t sc_ff;
  sacc_clk_t clk_ff;
  logic [9:0] cnt_ff, nxt_cnt;
  logic [3:0] bit_ff, nxt_bit;
  logic [10:0] sar_ff, nxt_sar;
  logic [1:0] settle_ff;
  logic [9:0] result_ff;
  logic flag_ff, nxt_flag;
  logic hi_read_ff, nxt_hi_read;
  logic ack_ff;
  logic [31:0] readdata_ff;
  logic [2:0] div_ff;
  logic [2:0] pin_meta_ff, pin_sync_ff, pin_last_ff;

  // ==========================================================
  // Bus decode
  wire req = avs_read | avs_write;
  wire acc = req & ack_ff;
  wire wr_en = acc & avs_write & avs_byteenable[0];
  wire wr_sc = wr_en & (avs_address == SACC_ADDR_SC);
  wire wr_clk = wr_en & (avs_address == SACC_ADDR_CLK);
  wire rd_rh = acc & avs_read & (avs_address == SACC_ADDR_RH);
  wire rd_rl = acc & avs_read & (avs_address == SACC_ADDR_RL);
  wire [4:0] wr_chan = avs_writedata[4:0];

  wire [31:0] rd_mux =
    (avs_address == SACC_ADDR_SC) ? {24'h000000, flag_ff, sc_ff} :
    (avs_address == SACC_ADDR_CLK) ? {25'h0000000, clk_ff} :
    (avs_address == SACC_ADDR_RH) ? {30'h00000000, result_ff[9:8]} :
    (avs_address == SACC_ADDR_RL) ? {24'h000000, result_ff[7:0]} : 32'h00000000;

  // One wait cycle, then the answer; data is latched during the wait
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = readdata_ff;

  // ==========================================================
  // Pin synchronisers: bit 0 oscillator, 1 async clock, 2 comparator
  wire [2:0] pin_raw = {comparator_in, async_clock_pin, oscillator_clock};
  wire osc_rise = pin_sync_ff[0] & ~pin_last_ff[0];
  wire acl_rise = pin_sync_ff[1] & ~pin_last_ff[1];
  wire cmp_s = pin_sync_ff[2];
  // A SAR decision waits until the trial word has stood three cycles, so the synchronised
  // comparator reflects it; a converter clock faster than a quarter of sys_clk gets stretched
  wire sar_ready = &settle_ff;

  // ==========================================================
  // Conversion control
  wire busy = (state_ff != SACC_IDLE);
  wire clocks_on = (state_ff == SACC_SETTLE) | (state_ff == SACC_SAMPLE) | (state_ff == SACC_CONVERT);
  wire stop_abort = stop_mode & ~clk_ff.async_clock_enable & busy;
  wire abort = wr_sc | wr_clk | stop_abort;
  wire restart = wr_sc & (wr_chan != SACC_CHAN_OFF);
  wire blocked = clk_ff.resolution_10 & hi_read_ff;
  wire xfer = (state_ff == SACC_TRANSFER) & ~blocked & ~abort;

  // Source clock selection and divider
  wire src_tick = clk_ff.async_clock_enable ? acl_rise :
                  (clk_ff.input_clock_select ? 1'b1 : osc_rise);
  wire [2:0] div_mask = 3'((4'h1 << clk_ff.clock_divide) - 4'h1);
  wire converter_clock_tick = clocks_on & src_tick & (div_ff == div_mask);

  wire [9:0] sample_len = clk_ff.resolution_10 ?
    (clk_ff.long_sample_select ? SACC_SMP_10L : SACC_SMP_10S) :
    (clk_ff.long_sample_select ? SACC_SMP_8L : SACC_SMP_8S);

  // Round the 11-bit SAR word and clamp at full scale
  function automatic logic [9:0] sacc_format(input logic [10:0] raw, input logic ten);
    logic [10:0] r10;
    logic [8:0] r8;
    r10 = {1'b0, raw[10:1]} + {10'h000, raw[0]};
    r8 = {1'b0, raw[10:3]} + {8'h00, raw[2]};
    if (ten) begin
      sacc_format = r10[10] ? 10'h3FF : r10[9:0];
    end else begin
      sacc_format = {2'h0, (r8[8] ? 8'hFF : r8[7:0])};
    end
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sar = sar_ff;
    case (state_ff)
      SACC_IDLE: begin
        nxt_cnt = 10'h000;
      end
      SACC_SYNC: begin
        if (cnt_ff == SACC_SYNC_CYC - 10'h001) begin
          nxt_cnt = 10'h000;
          nxt_state = clk_ff.async_clock_enable ? SACC_STARTUP : SACC_SETTLE;
        end else begin
          nxt_cnt = cnt_ff + 10'h001;
        end
      end
      SACC_STARTUP: begin
        if (cnt_ff == SACC_STARTUP_CYC - 10'h001) begin
          nxt_cnt = 10'h000;
          nxt_state = SACC_SETTLE;
        end else begin
          nxt_cnt = cnt_ff + 10'h001;
        end
      end
      SACC_SETTLE: begin
        if (converter_clock_tick) begin
          if (cnt_ff == SACC_FIRST_EXTRA_CONVERTER_CLOCK - 10'h001) begin
            nxt_cnt = 10'h000;
            nxt_state = SACC_SAMPLE;
          end else begin
            nxt_cnt = cnt_ff + 10'h001;
          end
        end
      end
      SACC_SAMPLE: begin
        if (converter_clock_tick) begin
          if (cnt_ff == sample_len - 10'h001) begin
            nxt_cnt = 10'h000;
            nxt_bit = SACC_SAR_MSB;
            nxt_sar = 11'h400;
            nxt_state = SACC_CONVERT;
          end else begin
            nxt_cnt = cnt_ff + 10'h001;
          end
        end
      end
      SACC_CONVERT: begin
        if (converter_clock_tick && sar_ready) begin
          if (!cmp_s) begin
            nxt_sar[bit_ff] = 1'b0;
          end
          if (bit_ff == 4'h0) begin
            nxt_state = SACC_TRANSFER;
          end else begin
            nxt_sar[bit_ff - 4'h1] = 1'b1;
            nxt_bit = bit_ff - 4'h1;
          end
        end
      end
      SACC_TRANSFER: begin
        if (blocked || sc_ff.continuous_select) begin
          nxt_state = SACC_SAMPLE;
        end else begin
          nxt_state = SACC_IDLE;
        end
      end
      default: begin
        nxt_state = SACC_IDLE;
      end
    endcase
    if (abort) begin
      nxt_cnt = 10'h000;
      nxt_state = restart ? SACC_SYNC : SACC_IDLE;
    end
  end

  // Flag set beats a same-cycle clear by software
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_sc || rd_rl) begin
      nxt_flag = 1'b0;
    end
    if (xfer) begin
      nxt_flag = 1'b1;
    end
    nxt_hi_read = hi_read_ff;
    if (rd_rl) begin
      nxt_hi_read = 1'b0;
    end
    if (rd_rh && clk_ff.resolution_10) begin
      nxt_hi_read = 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  assign irq = flag_ff & sc_ff.complete_irq_enable;
  assign converter_input = sc_ff.channel_select;
  assign mux_enable = busy & ~abort;
  assign sample_enable = (state_ff == SACC_SAMPLE) & ~abort;
  // Gated straight from abort so power drops in the same cycle
  assign ref_enable = busy & ~abort;
  assign async_osc_enable = busy & ~abort & clk_ff.async_clock_enable;
  assign async_osc_low_power = clk_ff.low_power_config;
  assign sar_code = sar_ff;

  // ==========================================================
  // Flip-flops
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      pin_meta_ff <= 3'h0;
      pin_sync_ff <= 3'h0;
      pin_last_ff <= 3'h0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
      pin_last_ff <= pin_sync_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      readdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= req & ~ack_ff;
      if (req && !ack_ff) begin
        readdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sc_ff <= SACC_SC_RST;
      clk_ff <= SACC_CLK_RST;
    end else begin
      if (wr_sc) begin
        sc_ff <= sacc_sc_t'(avs_writedata[6:0]);
      end
      if (wr_clk) begin
        clk_ff <= sacc_clk_t'(avs_writedata[6:0]);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      div_ff <= 3'h0;
    end else if (!clocks_on || abort) begin
      div_ff <= 3'h0;
    end else if (src_tick) begin
      div_ff <= (div_ff == div_mask) ? 3'h0 : div_ff + 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff <= SACC_IDLE;
      cnt_ff <= 10'h000;
      bit_ff <= 4'h0;
      sar_ff <= 11'h000;
      settle_ff <= 2'h0;
      flag_ff <= 1'b0;
      hi_read_ff <= 1'b0;
      result_ff <= 10'h000;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sar_ff <= nxt_sar;
      settle_ff <= (nxt_sar != sar_ff) ? 2'h0 : (sar_ready ? settle_ff : settle_ff + 2'h1);
      flag_ff <= nxt_flag;
      hi_read_ff <= nxt_hi_read;
      if (xfer) begin
        result_ff <= sacc_format(sar_ff, clk_ff.resolution_10);
      end
    end
  end

endmodule

//--- tb/sacc_checker.sv
/*
  Port-level assertions for the SAR converter control top.
  Assumes one clock domain and a bus master that holds each request until accepted.
*/
`timescale 1ns/10ps
module sacc_checker
  import sacc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register bus
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Converter side
  input wire logic stop_mode,
  input wire logic irq,
  input wire logic async_osc_enable,
  input wire logic async_osc_low_power,
  input wire logic [4:0] converter_input,
  input wire logic mux_enable,
  input wire logic ref_enable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // ======
  // Accepted register writes
  wire logic acc_wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire logic sc_wr = acc_wr & (avs_address == SACC_ADDR_SC);
  wire logic clk_wr = acc_wr & (avs_address == SACC_ADDR_CLK);
  // ======
  // Properties
  a_chan_follow: assert property (sc_wr |=> converter_input == $past(avs_writedata[4:0]))
    else $error("channel not taken");
  a_write_abort: assert property (sc_wr | clk_wr |-> !mux_enable && !ref_enable)
    else $error("write did not abort");
  a_stop_abort: assert property (stop_mode && !async_osc_enable |-> !ref_enable)
    else $error("stop did not power down");
  a_irq_clear: assert property (sc_wr && !avs_writedata[6] |=> !irq)
    else $error("irq after disabling write");
  a_lp_follow: assert property (clk_wr |=> async_osc_low_power == $past(avs_writedata[5]))
    else $error("range bit not taken");
  a_async_busy: assert property (async_osc_enable |-> mux_enable)
    else $error("async clock while idle");
  a_reset_idle: assert property ($rose(rst_b) |-> !irq && !mux_enable && converter_input == SACC_CHAN_OFF)
    else $error("bad state after reset");
  a_idle_holds: assert property (!mux_enable && !avs_write |=> !mux_enable)
    else $error("start without a write");
  c_start: cover property (sc_wr && avs_writedata[4:0] != SACC_CHAN_OFF);
  c_irq: cover property ($rose(irq));
  c_stop_async: cover property (stop_mode && async_osc_enable);
endmodule
bind sacc_top sacc_checker chk_u (
  .sys_clk, .rst_b, .avs_address, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_waitrequest, .stop_mode, .irq, .async_osc_enable, .async_osc_low_power,
  .converter_input, .mux_enable, .ref_enable
);

//--- tb/tb.sv
/*
  Self-checking bench for the SAR converter control top.
  Assumes the comparator keeps a trial bit while the held input is at or above sar_code.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  import sacc_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic stop_mode = 1'b0, comparator_in = 1'b0, oscillator_clock = 1'b0, async_clock_pin = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic avs_waitrequest, irq, async_osc_enable, async_osc_low_power;
  logic mux_enable, sample_enable, ref_enable, hit, ten, lng;
  logic [4:0] converter_input, ch;
  logic [10:0] sar_code, vin = 11'h0;
  logic [7:0] lastrl = 8'h00;
  logic [2:0] tick = 3'h0;
  int num_errors = 0, comparisons = 0, n, i;
  // ======
  // Clocks and analog model
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tick <= tick + 3'h1;
    oscillator_clock <= tick[2];
    async_clock_pin <= async_osc_enable & tick[2];
    comparator_in <= (vin >= sar_code);
  end
  sacc_top dut_u (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .stop_mode, .irq, .oscillator_clock,
    .async_clock_pin, .async_osc_enable, .async_osc_low_power, .comparator_in, .converter_input,
    .mux_enable, .sample_enable, .ref_enable, .sar_code);
  // ======
  // Tasks and models
  task automatic results();
    $display("checks=%0d errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      num_errors++;
      results();
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic wait_hi(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    hit = (irq === 1'b1);
  endtask
  function automatic logic [9:0] expect_res(input logic [10:0] v, input logic t);
    logic [11:0] r;
    r = t ? (12'(v) + 12'h001) >> 1 : (12'(v) + 12'h004) >> 3;
    if (t && r > 12'h3FF)
      r = 12'h3FF;
    if (!t && r > 12'h0FF)
      r = 12'h0FF;
    return r[9:0];
  endfunction
  // Worst case in sys cycles on the bus clock; SAR steps never come faster than every four cycles
  function automatic int lim(input logic t, input logic l, input logic [1:0] d, input logic f);
    int c;
    c = t ? (l ? 41 : 21) : (l ? 38 : 18);
    if (!f)
      c = c - 2;
    return (c + 1) * ((d < 2'h2) ? 4 : (1 << d)) + 4;
  endfunction
  task automatic check_res();
    logic [9:0] e;
    e = expect_res(vin, ten);
    bus(1'b0, SACC_ADDR_RH, 32'h0);
    `CHK(rd[1:0], ten ? e[9:8] : 2'h0)
    bus(1'b0, SACC_ADDR_RL, 32'h0);
    `CHK(rd[7:0], e[7:0])
    `CHK(irq, 1'b0)
    lastrl = e[7:0];
  endtask
  // ======
  // Main sequence
  initial begin
    n = $urandom(34);
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    bus(1'b0, SACC_ADDR_SC, 32'h0);
    `CHK(rd[7:0], 8'h1F)
    bus(1'b0, SACC_ADDR_RL, 32'h0);
    `CHK(rd[7:0], 8'h00)
    bus(1'b0, 4'h2, 32'h0);
    `CHK(rd, 32'h0)
    // Every resolution, sample length and divider, saturating first
    for (i = 0; i < 8; i++) begin
      ten = i[0] ^ i[2];
      lng = i[2];
      vin = (i == 0) ? 11'h7FF : (i == 1) ? 11'h000 : 11'($urandom);
      ch = 5'($urandom % 31);
      bus(1'b1, SACC_ADDR_CLK, {25'h0, ten, i[1], lng, i[1:0], 2'b01});
      bus(1'b0, SACC_ADDR_CLK, 32'h0);
      `CHK(rd[6:0], {ten, i[1], lng, i[1:0], 2'b01})
      `CHK(async_osc_low_power, i[1])
      bus(1'b1, SACC_ADDR_SC, {25'h0, 2'b10, ch});
      `CHK(converter_input, ch)
      `CHK(mux_enable, 1'b1)
      // One extra converter clock covers divider phase, four edges the transfer
      wait_hi(lim(ten, lng, i[1:0], 1'b1));
      `CHK(hit, 1'b1)
      bus(1'b0, SACC_ADDR_SC, 32'h0);
      `CHK(rd[7], 1'b1)
      check_res();
      `CHK(mux_enable, 1'b0)
    end
    // Continuous run, then stop it
    ten = 1'b1;
    bus(1'b1, SACC_ADDR_CLK, 32'h41);
    bus(1'b1, SACC_ADDR_SC, 32'h65);
    wait_hi(lim(1'b1, 1'b0, 2'h0, 1'b1));
    `CHK(hit, 1'b1)
    check_res();
    wait_hi(lim(1'b1, 1'b0, 2'h0, 1'b0));
    `CHK(hit, 1'b1)
    bus(1'b1, SACC_ADDR_SC, 32'h1F);
    `CHK(irq, 1'b0)
    repeat (60) @(negedge sys_clk);
    `CHK(mux_enable, 1'b0)
    // Aborts by control write, clock write and stop
    ten = 1'b0;
    for (i = 0; i < 3; i++) begin
      vin = 11'($urandom);
      bus(1'b1, SACC_ADDR_CLK, 32'h01);
      bus(1'b1, SACC_ADDR_SC, 32'h49);
      repeat (8) @(negedge sys_clk);
      if (i == 0)
        bus(1'b1, SACC_ADDR_SC, 32'h5F);
      else if (i == 1)
        bus(1'b1, SACC_ADDR_CLK, 32'h01);
      else begin
        @(posedge sys_clk);
        stop_mode <= 1'b1;
        @(posedge sys_clk);
        stop_mode <= 1'b0;
        @(negedge sys_clk);
      end
      `CHK(mux_enable, 1'b0)
      `CHK(sample_enable, 1'b0)
      repeat (40) @(negedge sys_clk);
      `CHK(irq, 1'b0)
      bus(1'b0, SACC_ADDR_RL, 32'h0);
      `CHK(rd[7:0], lastrl)
    end
    // High byte read mid-conversion blocks the transfer
    ten = 1'b1;
    vin = 11'($urandom);
    bus(1'b1, SACC_ADDR_CLK, 32'h41);
    bus(1'b1, SACC_ADDR_SC, 32'h4C);
    bus(1'b0, SACC_ADDR_RH, 32'h0);
    repeat (60) @(negedge sys_clk);
    `CHK(irq, 1'b0)
    `CHK(mux_enable, 1'b1)
    bus(1'b0, SACC_ADDR_RL, 32'h0);
    `CHK(rd[7:0], lastrl)
    wait_hi(lim(1'b1, 1'b0, 2'h0, 1'b0));
    `CHK(hit, 1'b1)
    check_res();
    // Asynchronous clock carries on through stop
    ten = 1'b0;
    bus(1'b1, SACC_ADDR_CLK, 32'h03);
    bus(1'b1, SACC_ADDR_SC, 32'h47);
    @(posedge sys_clk);
    stop_mode <= 1'b1;
    wait_hi(800);
    `CHK(hit, 1'b1)
    `CHK(async_osc_enable, 1'b0)
    @(posedge sys_clk);
    stop_mode <= 1'b0;
    check_res();
    // Alternate clock with the interrupt masked
    vin = 11'($urandom);
    bus(1'b1, SACC_ADDR_CLK, 32'h00);
    bus(1'b1, SACC_ADDR_SC, 32'h02);
    repeat (200) @(negedge sys_clk);
    `CHK(irq, 1'b0)
    bus(1'b0, SACC_ADDR_SC, 32'h0);
    `CHK(rd[7:0], 8'h82)
    check_res();
    results();
  end
endmodule
